// ===== rtl/sspi_pkg.sv
// Package for the serial memory slave: link structs, opcodes, status layout.
// Assumes one core clock that oversamples the serial clock.
package sspi_pkg;
    localparam int ADDR_W = 13;
    localparam int WORD_W = 8;
    localparam int CMD_W = 8;
    localparam int ADDR_FIELD_W = 16;
    localparam int PAGE_W = 5;
    localparam logic [12:0] ADDR_RST = 13'h0000;
    localparam logic [7:0] MSR_RST = 8'h02;
    localparam int MSR_FIXED_ONE_BIT = 1;
    localparam int MSR_MODE_LO_BIT = 6;
    localparam int MSR_MODE_HI_BIT = 7;
    localparam int MSR_FUNC_BIT = 0;
    localparam logic [7:0] MSR_WR_MASK = 8'hc1;
    localparam logic [4:0] CNT_RST = 5'h00;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [4:0] ADDR_BITS_LAST = 5'h0f;
    // Default opcodes and mode codes, arbitrary values; overridable at the top
    localparam logic [7:0] WRITE_CMD_DEF = 8'h02;
    localparam logic [7:0] READ_CMD_DEF = 8'h03;
    localparam logic [7:0] WRITE_STATUS_CMD_DEF = 8'h01;
    localparam logic [7:0] READ_STATUS_CMD_DEF = 8'h05;
    localparam logic [1:0] MODE_PAGE_DEF = 2'h2;
    localparam logic [1:0] MODE_BURST_DEF = 2'h1;

    typedef struct packed {
        logic sel_n;
        logic sck;
        logic sin;
        logic pause_n;
    } sspi_pins_t;

    typedef struct packed {
        logic we;
        logic [12:0] addr;
        logic [7:0] data;
    } sspi_mem_wr_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_WSTAT, ST_RSTAT, ST_SINK
    } sspi_state_t;
endpackage

// ===== rtl/sspi_sync.sv
// Two-flop synchroniser bank for the serial pins.
// Assumes pins are asynchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module sspi_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // First stage is read only by the second stage
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_core_clk) begin
                if (i_sys_rst) begin
                    meta_ff[g] <= RST_VAL[g];
                    sync_ff[g] <= RST_VAL[g];
                end else if (i_ce) begin
                    meta_ff[g] <= i_async[g];
                    sync_ff[g] <= meta_ff[g];
                end
            end
        end
    endgenerate
    assign o_sync = sync_ff;
endmodule
`default_nettype wire

// ===== rtl/sspi_slave.sv
// Serial memory slave: instruction, address, data and status over a 5-wire link.
// Assumes the link clock is well below core rate (oversampled by i_core_clk).
`timescale 1ns/1ps
`default_nettype none
module sspi_slave
    import sspi_pkg::*;
#(
    parameter logic [7:0] WRITE_CMD = WRITE_CMD_DEF,
    parameter logic [7:0] READ_CMD = READ_CMD_DEF,
    parameter logic [7:0] WRITE_STATUS_CMD = WRITE_STATUS_CMD_DEF,
    parameter logic [7:0] READ_STATUS_CMD = READ_STATUS_CMD_DEF,
    parameter logic [1:0] MODE_PAGE = MODE_PAGE_DEF,
    parameter logic [1:0] MODE_BURST = MODE_BURST_DEF
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire sspi_pkg::sspi_pins_t i_pins,
    output logic o_sout,
    output logic o_sout_oe,
    output sspi_pkg::sspi_mem_wr_t o_mem_wr,
    input wire logic [7:0] i_mem_rdata,
    output logic [7:0] o_mode_status
);
    import sspi_pkg::*;

    sspi_pins_t pins_s;
    sspi_state_t state_ff;
    logic sck_d_ff;
    logic paused_ff;
    logic [7:0] sh_ff;
    logic [4:0] cnt_ff;
    logic [12:0] addr_ff;
    logic [7:0] msr_ff;
    logic [7:0] out_sh_ff;
    logic out_en_ff;
    logic sout_ff;
    sspi_mem_wr_t wr_ff;
    logic sel, rise, fall, live_rise, live_fall;
    logic [7:0] sh_nxt;
    logic [12:0] nxt_addr;

    // Pins cross into the core domain; idle levels keep select high, pause high
    sspi_sync #(.WIDTH(4), .RST_VAL(4'h9)) u_sync (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_async(i_pins),
        .o_sync(pins_s)
    );

    // Edge detection on the synchronised serial clock
    assign sel = !pins_s.sel_n;
    assign rise = pins_s.sck && !sck_d_ff;
    assign fall = !pins_s.sck && sck_d_ff;
    assign live_rise = rise && sel && !paused_ff;
    assign live_fall = fall && sel && !paused_ff;
    assign sh_nxt = {sh_ff[6:0], pins_s.sin};

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sck_d_ff <= 1'b0;
        end else if (i_ce) begin
            sck_d_ff <= pins_s.sck;
        end
    end

    // Pause tracking; entry waits for a falling clock when clock is high
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            paused_ff <= 1'b0;
        end else if (i_ce) begin
            if (!sel) begin
                paused_ff <= 1'b0;
            end else if (!paused_ff) begin
                // A detected fall leaves the synced clock low, so one test covers both cases
                if (!pins_s.pause_n && state_ff != ST_IDLE && !pins_s.sck) begin
                    paused_ff <= 1'b1;
                end
            end else if (pins_s.pause_n && !pins_s.sck) begin
                paused_ff <= 1'b0;
            end
        end
    end

    // Next address: page wraps in 32 words, burst wraps whole array
    always_comb begin
        if (msr_ff[MSR_MODE_HI_BIT:MSR_MODE_LO_BIT] == MODE_PAGE) begin
            nxt_addr = {addr_ff[12:PAGE_W], addr_ff[PAGE_W-1:0] + 5'h01};
        end else if (msr_ff[MSR_MODE_HI_BIT:MSR_MODE_LO_BIT] == MODE_BURST) begin
            nxt_addr = addr_ff + 13'h0001;
        end else begin
            nxt_addr = addr_ff;
        end
    end

    // Sequence engine, stepped on live serial-clock rises
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_ff <= ST_IDLE;
            sh_ff <= 8'h00;
            cnt_ff <= CNT_RST;
            addr_ff <= ADDR_RST;
            msr_ff <= MSR_RST;
            wr_ff <= '0;
        end else if (i_ce) begin
            wr_ff.we <= 1'b0;
            if (!sel) begin
                state_ff <= ST_IDLE;
                cnt_ff <= CNT_RST;
            end else if (state_ff == ST_IDLE) begin
                state_ff <= ST_CMD;
                cnt_ff <= CNT_RST;
            end else if (live_rise) begin
                sh_ff <= sh_nxt;
                cnt_ff <= cnt_ff + 5'h01;
                case (state_ff)
                    ST_CMD: begin
                        if (cnt_ff[2:0] == BIT_LAST) begin
                            cnt_ff <= CNT_RST;
                            if (sh_nxt == WRITE_CMD || sh_nxt == READ_CMD) begin
                                state_ff <= ST_ADDR;
                            end else if (sh_nxt == WRITE_STATUS_CMD) begin
                                state_ff <= ST_WSTAT;
                            end else if (sh_nxt == READ_STATUS_CMD) begin
                                state_ff <= ST_RSTAT;
                            end else begin
                                state_ff <= ST_SINK;
                            end
                            wr_ff.data <= sh_nxt;
                        end
                    end
                    ST_ADDR: begin
                        // Upper three address bits shift out and are dropped
                        addr_ff <= {addr_ff[11:0], pins_s.sin};
                        if (cnt_ff == ADDR_BITS_LAST) begin
                            cnt_ff <= CNT_RST;
                            state_ff <= (wr_ff.data == WRITE_CMD) ? ST_WDATA : ST_RDATA;
                        end
                    end
                    ST_WDATA: begin
                        if (cnt_ff[2:0] == BIT_LAST) begin
                            cnt_ff <= CNT_RST;
                            wr_ff.we <= 1'b1;
                            wr_ff.addr <= addr_ff;
                            wr_ff.data <= sh_nxt;
                            addr_ff <= nxt_addr;
                        end
                    end
                    ST_RDATA: begin
                        if (cnt_ff[2:0] == BIT_LAST) begin
                            cnt_ff <= CNT_RST;
                            addr_ff <= nxt_addr;
                        end
                    end
                    ST_WSTAT: begin
                        if (cnt_ff[2:0] == BIT_LAST) begin
                            // The mode bits and bit 0 store; bit 1 stays one
                            msr_ff <= (sh_nxt & MSR_WR_MASK) | MSR_RST;
                            state_ff <= ST_SINK;
                        end
                    end
                    ST_RSTAT: begin
                        // Counts rises so the status byte reloads at each word boundary
                        if (cnt_ff[2:0] == BIT_LAST) begin
                            cnt_ff <= CNT_RST;
                        end
                    end
                    ST_SINK: cnt_ff <= cnt_ff;
                    default: state_ff <= ST_IDLE;
                endcase
            end
        end
    end

    // Output shifter, loaded on the first fall of each read word, shifted on the later falls
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            out_sh_ff <= 8'h00;
            out_en_ff <= 1'b0;
            sout_ff <= 1'b0;
        end else if (i_ce) begin
            if (!sel) begin
                out_en_ff <= 1'b0;
            end else if (live_fall) begin
                if (state_ff == ST_RSTAT || state_ff == ST_RDATA) begin
                    sout_ff <= out_sh_ff[7];
                    out_sh_ff <= {out_sh_ff[6:0], out_sh_ff[7]};
                    out_en_ff <= 1'b1;
                    if (state_ff == ST_RDATA && cnt_ff == CNT_RST) begin
                        sout_ff <= i_mem_rdata[7];
                        out_sh_ff <= {i_mem_rdata[6:0], 1'b0};
                    end else if (state_ff == ST_RSTAT && cnt_ff == CNT_RST) begin
                        sout_ff <= msr_ff[7];
                        out_sh_ff <= {msr_ff[6:0], msr_ff[7]};
                    end
                end
            end
        end
    end

    // Raw pause pin gates the enable at once, ahead of any synchroniser
    assign o_sout_oe = out_en_ff && i_pins.pause_n && !paused_ff && !i_pins.sel_n;
    assign o_sout = sout_ff;
    assign o_mem_wr = wr_ff;
    assign o_mode_status = msr_ff;
endmodule
`default_nettype wire

// ===== verification/sspi_props.sv
// Port checker for the serial memory slave.
// Assumes one core clock domain and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module sspi_chk
    import sspi_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire sspi_pkg::sspi_pins_t i_pins,
    input wire logic o_sout_oe,
    input wire sspi_pkg::sspi_mem_wr_t o_mem_wr,
    input wire logic [7:0] o_mode_status
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    logic [12:0] last_ff;
    logic seen_ff;
    // Previous write address, forgotten between frames so wraps are judged per frame
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || i_pins.sel_n) seen_ff <= 1'b0;
        else if (o_mem_wr.we) seen_ff <= 1'b1;
        if (o_mem_wr.we) last_ff <= o_mem_wr.addr;
    end
    property p_sel_off; o_sout_oe |-> !i_pins.sel_n; endproperty
    a_sel_off: assert property (p_sel_off)
        else $error("output driven while deselected");
    property p_pause_off; !i_pins.pause_n |-> !o_sout_oe; endproperty
    a_pause_off: assert property (p_pause_off)
        else $error("output driven while paused");
    property p_we_pulse; o_mem_wr.we |=> !o_mem_wr.we; endproperty
    a_we_pulse: assert property (p_we_pulse)
        else $error("write strobe longer than one cycle");
    property p_fixed; o_mode_status[MSR_FIXED_ONE_BIT] && o_mode_status[5:2] == 4'h0; endproperty
    a_fixed: assert property (p_fixed)
        else $error("status fixed bits wrong");
    property p_desel; i_pins.sel_n [*8] |-> !o_mem_wr.we && $stable(o_mode_status); endproperty
    a_desel: assert property (p_desel)
        else $error("activity while deselected");
    property p_paused; !i_pins.pause_n [*8] |-> !o_mem_wr.we; endproperty
    a_paused: assert property (p_paused)
        else $error("write while paused");
    property p_burst;
        o_mem_wr.we && seen_ff && o_mode_status[7:6] == MODE_BURST_DEF
            |-> o_mem_wr.addr == last_ff + 13'h1;
    endproperty
    a_burst: assert property (p_burst)
        else $error("burst address step wrong");
    property p_page;
        o_mem_wr.we && seen_ff && o_mode_status[7:6] == MODE_PAGE_DEF
            |-> o_mem_wr.addr == {last_ff[12:5], last_ff[4:0] + 5'h1};
    endproperty
    a_page: assert property (p_page)
        else $error("page address step wrong");
endmodule
bind sspi_slave sspi_chk sspi_chk_i (.i_core_clk, .i_sys_rst, .i_pins, .o_sout_oe, .o_mem_wr,
    .o_mode_status);
`default_nettype wire

// ===== verification/sspi_host.sv
// Host link master model: select, clock, data and pause pins.
// Assumes the core clock paces it; one bit takes 200 ns.
`timescale 1ns/1ps
`default_nettype none
module sspi_host
    import sspi_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sout,
    input wire logic i_sout_oe,
    output sspi_pkg::sspi_pins_t o_pins
);
    logic last_so = 1'b0;
    // A released output line shows the inverse of the last driven bit, never the old bit
    always @(posedge i_core_clk) if (i_sout_oe) last_so <= i_sout;
    wire logic so_line = i_sout_oe ? i_sout : ~last_so;
    initial o_pins = '{sel_n: 1'b1, sck: 1'b0, sin: 1'b0, pause_n: 1'b1};
    task automatic half();
        repeat (4) @(negedge i_core_clk);
    endtask
    task automatic sel(input logic lvl);
        half();
        o_pins.sel_n = lvl;
        half();
    endtask
    // One byte MSB first; pause with clock low before bit pb, clock busy meanwhile
    task automatic xfer(input logic [7:0] tx, input int pb, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            if (i == pb) begin
                o_pins.pause_n = 1'b0;
                repeat (4) begin
                    half();
                    o_pins.sck = ~o_pins.sck;
                    o_pins.sin = ~o_pins.sin;
                end
                half();
                o_pins.pause_n = 1'b1;
            end
            o_pins.sin = tx[i];
            half();
            o_pins.sck = 1'b1;
            half();
            rx[i] = so_line;
            o_pins.sck = 1'b0;
        end
    endtask
    // One clock pulse with pause dropped while the clock is high; entry waits for the fall
    task automatic hold_hi(output logic oe_seen);
        o_pins.sin = 1'b0;
        half();
        o_pins.sck = 1'b1;
        half();
        o_pins.pause_n = 1'b0;
        #1 oe_seen = i_sout_oe;
        half();
        o_pins.sck = 1'b0;
        repeat (4) begin
            half();
            o_pins.sck = ~o_pins.sck;
        end
        half();
        o_pins.pause_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== verification/sspi_slave_test.sv
// Self-checking bench for the serial memory slave.
// Assumes the host model drives all pins off the falling core edge.
`timescale 1ns/1ps
`default_nettype none
module sspi_slave_test;
    import sspi_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    sspi_pins_t pins;
    logic sout;
    logic sout_oe;
    sspi_mem_wr_t mem_wr;
    logic [7:0] status;
    logic [7:0] rx;
    logic ce = 1'b1;
    logic [7:0] rdata = 8'h00;
    int fails = 0;
    int checks_done = 0;
    sspi_mem_wr_t wr_q[$];
    always #12.5 i_core_clk = ~i_core_clk;
    sspi_slave sspi_slave_i (.i_core_clk, .i_sys_rst, .i_ce(ce), .i_pins(pins), .o_sout(sout),
        .o_sout_oe(sout_oe), .o_mem_wr(mem_wr), .i_mem_rdata(rdata), .o_mode_status(status));
    sspi_host sspi_host_i (.i_core_clk, .i_sout(sout), .i_sout_oe(sout_oe), .o_pins(pins));
    // Every write strobe is queued mid-cycle, where it has settled, for the scenarios to judge
    always @(negedge i_core_clk) if (mem_wr.we === 1'b1) wr_q.push_back(mem_wr);
    task automatic check(input logic [12:0] got, input logic [12:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cwr(input logic [12:0] a, input logic [7:0] d);
        sspi_mem_wr_t w;
        w = (wr_q.size() > 0) ? wr_q.pop_front() : '0;
        check(w.addr, a, "addr");
        check({5'h00, w.data}, {5'h00, d}, "data");
    endtask
    task automatic rstat(input logic [7:0] e);
        sspi_host_i.sel(1'b0);
        sspi_host_i.xfer(READ_STATUS_CMD_DEF, 8, rx);
        sspi_host_i.xfer(8'h00, 8, rx);
        sspi_host_i.sel(1'b1);
        check({5'h00, rx}, {5'h00, e}, "status read");
    endtask
    task automatic wstat(input logic [7:0] v);
        sspi_host_i.sel(1'b0);
        sspi_host_i.xfer(WRITE_STATUS_CMD_DEF, 8, rx);
        sspi_host_i.xfer(v, 8, rx);
        sspi_host_i.sel(1'b1);
        check({5'h00, status}, {5'h00, v | 8'h02}, "status");
        rstat(v | 8'h02);
    endtask
    task automatic wframe(input logic [15:0] adr, input int pb, input int n, input logic [7:0] d0);
        sspi_host_i.sel(1'b0);
        sspi_host_i.xfer(WRITE_CMD_DEF, 8, rx);
        sspi_host_i.xfer(adr[15:8], 8, rx);
        sspi_host_i.xfer(adr[7:0], 8, rx);
        for (int k = 0; k < n; k++) sspi_host_i.xfer(d0 + 8'(k), (k == 0) ? pb : 8, rx);
        sspi_host_i.sel(1'b1);
    endtask
    task automatic t_reset();
        check({5'h00, status}, {5'h00, MSR_RST}, "reset status");
        check({12'h000, sout_oe}, 13'h0000, "idle oe");
        rstat(MSR_RST);
    endtask
    task automatic t_burst();
        wstat({MODE_BURST_DEF, 6'h01});
        wframe(16'hffff, 8, 3, 8'ha0);
        cwr(13'h1fff, 8'ha0);
        cwr(13'h0000, 8'ha1);
        cwr(13'h0001, 8'ha2);
    endtask
    task automatic t_page();
        wstat({MODE_PAGE_DEF, 6'h01});
        wframe(16'he05f, 8, 3, 8'hb0);
        cwr(13'h005f, 8'hb0);
        cwr(13'h0040, 8'hb1);
        cwr(13'h0041, 8'hb2);
        wframe(16'h0010, 3, 1, 8'h5a);
        cwr(13'h0010, 8'h5a);
    endtask
    // Word mode holds the address; a frame cut before data writes nothing
    task automatic t_word();
        wstat(8'h01);
        wframe(16'h0123, 8, 2, 8'hc0);
        cwr(13'h0123, 8'hc0);
        cwr(13'h0123, 8'hc1);
        wframe(16'h0200, 8, 0, 8'h00);
        check(13'(wr_q.size()), 13'h0000, "aborted frame");
    endtask
    // Clock enable low: a whole status-write frame must leave no trace
    task automatic t_freeze();
        ce = 1'b0;
        sspi_host_i.sel(1'b0);
        sspi_host_i.xfer(WRITE_STATUS_CMD_DEF, 8, rx);
        sspi_host_i.xfer(8'h41, 8, rx);
        sspi_host_i.sel(1'b1);
        ce = 1'b1;
        check({5'h00, status}, {5'h00, 8'h03}, "frozen status");
        rstat(8'h03);
    endtask
    // Word read, then a pause dropped with the clock high inside the next word
    task automatic t_read();
        logic [7:0] r0;
        logic oe_hi;
        rdata = 8'h96;
        sspi_host_i.sel(1'b0);
        sspi_host_i.xfer(READ_CMD_DEF, 8, rx);
        sspi_host_i.xfer(8'h00, 8, rx);
        sspi_host_i.xfer(8'h40, 8, rx);
        sspi_host_i.xfer(8'h00, 8, r0);
        sspi_host_i.hold_hi(oe_hi);
        sspi_host_i.xfer(8'h00, 8, rx);
        sspi_host_i.sel(1'b1);
        check({5'h00, r0}, {5'h00, rdata}, "read data");
        check({12'h000, oe_hi}, 13'h0000, "oe in pause");
        // One bit went out before the pause, so the next word is seen rotated by one
        check({5'h00, rx}, {5'h00, rdata[6:0], rdata[7]}, "resumed read");
        check(13'(wr_q.size()), 13'h0000, "read wrote");
    endtask
    task automatic close_out();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Reset for 12 cycles, then the scenarios in order
    initial begin
        repeat (12) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        repeat (4) @(negedge i_core_clk);
        t_reset();
        t_burst();
        t_page();
        t_word();
        t_freeze();
        t_read();
        close_out();
    end
endmodule
`default_nettype wire
